// file: shared/can_irq_pkg.sv
// Purpose: Constants and types shared by the CAN flag collection block.
// Assumes: One clock, synchronous active-low reset, APB register access.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - Event flags are set only by hardware and only software clears them.
// - Bit 15 records an invalid message event; zero when none recorded.
// - Bit 14 records wake-up activity seen on the bus.
// - Bit 13 records every bus error event.
// - Bit 12 records a system-side error such as a bad buffer address.
// - Bit 11 is read-only, high while any receive overflow is pending.
// - Bit 10 is read-only, high while any transmit attempt is pending.
// - Bits 9 to 5 of the flag register always read zero.
// - Bit 4 is read-only, high while a transmit event FIFO condition pends.
// - Bit 3 is set when current mode changes to equal requested mode.
// - Bit 2 is set when the timestamp base counter wraps past maximum.
// - Bit 1 is read-only, high while any receive object interrupt pends.
// - Bit 0 is read-only, high while any transmit object interrupt pends.
// - Receive pending bits 7 to 1 show FIFOs with enabled conditions pending.
// - Each pending bit ORs its FIFO's enabled flags; cleared only at the FIFO.
// - The upper receive pending register reads all zero.
// - Only flags whose enable bit is set raise the interrupt request.
// - Overflow summary follows per-FIFO flags, which are cleared at the FIFO.
`default_nettype none
package can_irq_pkg;
    // Flag register bit positions
    localparam int BIT_IVM   = 15;
    localparam int BIT_WAKE  = 14;
    localparam int BIT_BERR  = 13;
    localparam int BIT_SERR  = 12;
    localparam int BIT_RXOV  = 11;
    localparam int BIT_TXAT  = 10;
    localparam int BIT_TEF   = 4;
    localparam int BIT_MODE  = 3;
    localparam int BIT_TMR   = 2;
    localparam int BIT_RXOBJ = 1;
    localparam int BIT_TXOBJ = 0;
    // Implemented bit masks
    localparam logic [15:0] STICKY_MASK = 16'hf00c;
    localparam logic [15:0] FLAG_MASK   = 16'hfc1f;
    localparam logic [15:0] RXP_MASK    = 16'h00fe;
    // Register byte offsets
    localparam logic [11:0] ADDR_FLAGS    = 12'h000;
    localparam logic [11:0] ADDR_ENABLE   = 12'h004;
    localparam logic [11:0] ADDR_RXP_LOW  = 12'h008;
    localparam logic [11:0] ADDR_RXP_HIGH = 12'h00c;
    // Reset values
    localparam logic [15:0] FLAGS_RST  = 16'h0000;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] RXP_RST    = 16'h0000;
    // Sizes
    localparam int RX_FIFOS  = 8;
    localparam int FIFO_FLGS = 3;
    localparam int TSTAMP_W  = 32;
    // Bus answer state
    typedef enum logic {
        APB_IDLE = 1'b0,
        APB_DONE = 1'b1
    } apb_st_t;
endpackage
`default_nettype wire

// file: shared/flag_evt_if.sv
// Purpose: Carries sticky flag state and software clears between modules.
// Assumes: Same clock on both sides.
// Notes:   clr_wr is a one-cycle pulse; clr_data zero bits clear.
`default_nettype none
interface flag_evt_if;
    logic        clr_wr;
    logic [15:0] clr_data;
    logic [15:0] sticky;
    modport host (output clr_wr, output clr_data, input sticky);
    modport evt  (input clr_wr, input clr_data, output sticky);
endinterface
`default_nettype wire

// file: hdl/rx_pend_sum.sv
// Purpose: Per-FIFO receive pending summary.
// Assumes: FIFO flags and enables come from logic on the same clock.
// Notes:   One cycle of latency from the FIFO flags to the summary.
`default_nettype none
module rx_pend_sum #(
    parameter int FIFOS = can_irq_pkg::RX_FIFOS,
    parameter int FLGS  = can_irq_pkg::FIFO_FLGS
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // FIFO flags and their enables
    input  wire logic [FIFOS*FLGS-1:0] flags,
    input  wire logic [FIFOS*FLGS-1:0] flag_en,
    // Summary
    output logic      [FIFOS-1:0]      pend
);
    import can_irq_pkg::*;
    typedef struct packed {
        logic [FIFOS-1:0] pend;
    } sum_st_t;
    sum_st_t q;
    sum_st_t d;

    ////////////////////////////////////////////////////////////////////////
    // OR of each FIFO's enabled flags; FIFO 0 cannot receive
    always_comb begin
        d = q;
        for (int i = 0; i < FIFOS; i++) begin
            d.pend[i] = |(flags[i*FLGS +: FLGS] & flag_en[i*FLGS +: FLGS]);
        end
        d.pend[0] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pend = q.pend;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RXP_FOLLOWS: assert property (
        |(flags[FLGS +: FLGS] & flag_en[FLGS +: FLGS]) |=> pend[1])
        else $error("pending bit 1 did not follow enabled flags");
    AST_RXP_ZERO0: assert property (pend[0] == 1'b0)
        else $error("pending bit 0 not zero");
endmodule
`default_nettype wire

// file: hdl/evt_flags.sv
// Purpose: Sticky event flags with hardware set and software clear.
// Assumes: Event strobes come from logic on the same clock.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`default_nettype none
module evt_flags #(
    parameter int TSTAMP_W = can_irq_pkg::TSTAMP_W
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Event strobes
    input  wire logic                ivm_evt,
    input  wire logic                wake_evt,
    input  wire logic                berr_evt,
    input  wire logic                serr_evt,
    // Mode and time base
    input  wire logic [2:0]          current_op_mode,
    input  wire logic [2:0]          requested_op_mode,
    input  wire logic [TSTAMP_W-1:0] timestamp_base_counter,
    // Flag path to the register side
    flag_evt_if.evt                  fl
);
    import can_irq_pkg::*;
    typedef struct packed {
        logic [15:0]         sticky;
        logic [2:0]          mode_prev;
        logic [TSTAMP_W-1:0] stamp_prev;
    } evt_st_t;
    evt_st_t     q;
    evt_st_t     d;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic        mode_hit;
    logic        stamp_wrap;

    ////////////////////////////////////////////////////////////////////////
    // Detect mode arrival and time base wrap, then merge sets and clears
    always_comb begin
        d = q;
        mode_hit = (current_op_mode != q.mode_prev) &&
                   (current_op_mode == requested_op_mode);
        stamp_wrap = (&q.stamp_prev) && (timestamp_base_counter == '0);
        set_v = '0;
        set_v[BIT_IVM]  = ivm_evt;
        set_v[BIT_WAKE] = wake_evt;
        set_v[BIT_BERR] = berr_evt;
        set_v[BIT_SERR] = serr_evt;
        set_v[BIT_MODE] = mode_hit;
        set_v[BIT_TMR]  = stamp_wrap;
        // Zero written clears, one written keeps
        clr_v = fl.clr_wr ? ~fl.clr_data : 16'h0000;
        // Only software clears; the set term is ORed last so it wins
        d.sticky = ((q.sticky & ~clr_v) | set_v) & STICKY_MASK;
        d.mode_prev  = current_op_mode;
        d.stamp_prev = timestamp_base_counter;
    end

    // Edge trackers follow the inputs even in reset, so a mode held
    // across reset is not taken for a fresh arrival afterwards
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.sticky     <= FLAGS_RST;
            q.mode_prev  <= current_op_mode;
            q.stamp_prev <= timestamp_base_counter;
        end else begin
            q <= d;
        end
    end

    assign fl.sticky = q.sticky;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_clear_ivm;
        fl.clr_wr && !fl.clr_data[BIT_IVM];
    endsequence

    AST_SET_WINS: assert property (s_clear_ivm ##0 ivm_evt |=> fl.sticky[BIT_IVM])
        else $error("invalid message set lost to a clear");
    AST_CLEAR_WORKS: assert property (
        s_clear_ivm ##0 !ivm_evt |=> !fl.sticky[BIT_IVM])
        else $error("zero write did not clear flag");
    AST_NO_SELF_CLEAR: assert property (
        fl.sticky[BIT_BERR] && !fl.clr_wr |=> fl.sticky[BIT_BERR])
        else $error("bus error flag dropped without a clear");
    AST_MODE_SET: assert property (
        current_op_mode != $past(current_op_mode) &&
        current_op_mode == requested_op_mode |=> fl.sticky[BIT_MODE])
        else $error("mode change flag not set");
    AST_TMR_SET: assert property (
        (&timestamp_base_counter) ##1 (timestamp_base_counter == '0)
        |=> fl.sticky[BIT_TMR])
        else $error("timer wrap flag not set");
endmodule
`default_nettype wire

// file: hdl/can_irq_flags.sv
// Purpose: CAN flag register, enable register and receive pending summary
//          behind an APB slave, with one interrupt request out.
// Assumes: All event and FIFO inputs come from logic on CLK.
// Notes:   Every access takes one wait state; unmapped addresses answer
//          with PSLVERR and read zero.
`default_nettype none
module can_irq_flags #(
    parameter int FIFOS    = can_irq_pkg::RX_FIFOS,
    parameter int FLGS     = can_irq_pkg::FIFO_FLGS,
    parameter int TSTAMP_W = can_irq_pkg::TSTAMP_W
) (
    // Clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    // APB slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [11:0]           PADDR,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // Event strobes
    input  wire logic                  IVM_EVT,
    input  wire logic                  WAKE_EVT,
    input  wire logic                  BERR_EVT,
    input  wire logic                  SERR_EVT,
    // Mode and time base
    input  wire logic [2:0]            CURRENT_OP_MODE,
    input  wire logic [2:0]            REQUESTED_OP_MODE,
    input  wire logic [TSTAMP_W-1:0]   TIMESTAMP_BASE_COUNTER,
    // Per-FIFO sources
    input  wire logic [FIFOS*FLGS-1:0] RX_FIFO_FLAGS,
    input  wire logic [FIFOS*FLGS-1:0] RX_FIFO_FLAG_EN,
    input  wire logic [FIFOS-1:1]      RX_FIFO_OVERFLOW,
    input  wire logic [FIFOS-1:0]      TX_ATTEMPT_PENDING,
    input  wire logic [FIFOS-1:0]      TX_FIFO_PENDING,
    input  wire logic                  TX_EVENT_FIFO_PENDING,
    // Interrupt request
    output logic                       IRQ_REQ
);
    import can_irq_pkg::*;

    typedef struct packed {
        apb_st_t     st;
        logic [31:0] prdata;
        logic        pslverr;
        logic [15:0] enable;
        logic        irq;
    } top_st_t;

    top_st_t          q;
    top_st_t          d;
    flag_evt_if       fl ();
    logic [FIFOS-1:0] rx_fifo_pending;
    logic [15:0]      flag_view;
    logic [15:0]      rxp_low;
    logic [32:0]      rd_word;
    logic             acc_start;
    logic             acc_done;
    logic             wr_commit;

    ////////////////////////////////////////////////////////////////////////
    // Register map read; bit 32 flags an unmapped address
    function automatic logic [32:0] read_map(
        input logic [11:0] a,
        input logic [15:0] flags,
        input logic [15:0] en,
        input logic [15:0] rxp
    );
        logic [32:0] r;
        r = 33'h0_0000_0000;
        unique case (a)
            ADDR_FLAGS:    r[15:0] = flags & FLAG_MASK;
            ADDR_ENABLE:   r[15:0] = en;
            ADDR_RXP_LOW:  r[15:0] = rxp & RXP_MASK;
            ADDR_RXP_HIGH: r[15:0] = RXP_RST;
            default:       r[32]   = 1'b1;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags and receive summary
    evt_flags #(
        .TSTAMP_W (TSTAMP_W)
    ) u_evt (
        .clk                    (CLK),
        .rst_n                  (RST_N),
        .ivm_evt                (IVM_EVT),
        .wake_evt               (WAKE_EVT),
        .berr_evt               (BERR_EVT),
        .serr_evt               (SERR_EVT),
        .current_op_mode        (CURRENT_OP_MODE),
        .requested_op_mode      (REQUESTED_OP_MODE),
        .timestamp_base_counter (TIMESTAMP_BASE_COUNTER),
        .fl                     (fl.evt)
    );

    rx_pend_sum #(
        .FIFOS (FIFOS),
        .FLGS  (FLGS)
    ) u_rxp (
        .clk     (CLK),
        .rst_n   (RST_N),
        .flags   (RX_FIFO_FLAGS),
        .flag_en (RX_FIFO_FLAG_EN),
        .pend    (rx_fifo_pending)
    );

    ////////////////////////////////////////////////////////////////////////
    // Flag register view: sticky bits plus live read-only summaries.
    // Summaries follow their sources, so clearing happens at the FIFOs.
    always_comb begin
        flag_view            = fl.sticky & STICKY_MASK;
        flag_view[BIT_RXOV]  = |RX_FIFO_OVERFLOW;
        flag_view[BIT_TXAT]  = |TX_ATTEMPT_PENDING;
        flag_view[BIT_TEF]   = TX_EVENT_FIFO_PENDING;
        flag_view[BIT_RXOBJ] = |rx_fifo_pending;
        flag_view[BIT_TXOBJ] = |TX_FIFO_PENDING;
        rxp_low              = 16'h0000;
        rxp_low[FIFOS-1:0]   = rx_fifo_pending;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB handshake. The answer is registered so PREADY comes from a
    // flip-flop; the price is one wait state on every access.
    assign acc_start = PSEL && PENABLE && (q.st == APB_IDLE);
    assign acc_done  = PSEL && PENABLE && (q.st == APB_DONE);
    assign wr_commit = acc_done && PWRITE && !q.pslverr;
    assign rd_word   = read_map(PADDR, flag_view, q.enable, rxp_low);

    // Clear pulse toward the sticky flags; only low-lane bytes carry flags
    always_comb begin
        fl.clr_wr   = wr_commit && (PADDR == ADDR_FLAGS);
        fl.clr_data = PWDATA[15:0];
        if (!PSTRB[0]) begin
            fl.clr_data[7:0] = 8'hff;
        end
        if (!PSTRB[1]) begin
            fl.clr_data[15:8] = 8'hff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: bus answer, enable register, interrupt request
    always_comb begin
        d = q;
        unique case (q.st)
            APB_IDLE: begin
                if (acc_start) begin
                    d.st      = APB_DONE;
                    d.prdata  = PWRITE ? 32'h0000_0000 : rd_word[31:0];
                    d.pslverr = rd_word[32];
                end
            end
            APB_DONE: begin
                d.st      = APB_IDLE;
                d.pslverr = 1'b0;
            end
        endcase
        // Enable register write, byte lanes honoured
        if (wr_commit && (PADDR == ADDR_ENABLE)) begin
            if (PSTRB[0]) begin
                d.enable[7:0] = PWDATA[7:0] & FLAG_MASK[7:0];
            end
            if (PSTRB[1]) begin
                d.enable[15:8] = PWDATA[15:8] & FLAG_MASK[15:8];
            end
        end
        // Only enabled flags reach the request
        d.irq = |(flag_view & q.enable);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            q.st      <= APB_IDLE;
            q.prdata  <= 32'h0000_0000;
            q.pslverr <= 1'b0;
            q.enable  <= ENABLE_RST;
            q.irq     <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA  = q.prdata;
    assign PREADY  = (q.st == APB_DONE);
    assign PSLVERR = q.pslverr; // Only ever set together with the answer
    assign IRQ_REQ = q.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_read_flags;
        PSEL && PENABLE && !PWRITE && (PADDR == ADDR_FLAGS) && !PREADY;
    endsequence

    sequence s_read_high;
        PSEL && PENABLE && !PWRITE && (PADDR == ADDR_RXP_HIGH) && !PREADY;
    endsequence

    AST_READY_ONE_WAIT: assert property (
        s_setup ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
        else $error("access did not complete after one wait state");
    AST_FLAGS_RSVD: assert property (
        s_read_flags |=> PRDATA[9:5] == 5'h00 && PRDATA[31:16] == 16'h0000)
        else $error("unimplemented flag bits read nonzero");
    AST_RXP_HIGH_ZERO: assert property (s_read_high |=> PRDATA == 32'h0000_0000)
        else $error("upper receive pending register read nonzero");
    AST_IRQ_GATE: assert property (
        (flag_view & q.enable) == 16'h0000 |=> !IRQ_REQ)
        else $error("request raised with no enabled flag");
    AST_IRQ_RAISE: assert property (
        fl.sticky[BIT_IVM] && q.enable[BIT_IVM] |=> IRQ_REQ)
        else $error("enabled flag did not raise request");
    // Summaries are checked through the read path, not the view itself
    AST_SUMMARY_RO: assert property (
        s_read_flags |=> PRDATA[BIT_RXOV] == (|$past(RX_FIFO_OVERFLOW)))
        else $error("overflow summary read wrong");
    AST_TXAT_READ: assert property (
        s_read_flags |=> PRDATA[BIT_TXAT] == (|$past(TX_ATTEMPT_PENDING)))
        else $error("transmit attempt summary read wrong");
    AST_TEF_READ: assert property (
        s_read_flags |=> PRDATA[BIT_TEF] == $past(TX_EVENT_FIFO_PENDING))
        else $error("transmit event summary read wrong");
    AST_RXOBJ_READ: assert property (
        s_read_flags |=> PRDATA[BIT_RXOBJ] == (|$past(rx_fifo_pending)))
        else $error("receive object summary read wrong");
    AST_TXOBJ_LIVE: assert property (
        s_read_flags |=> PRDATA[BIT_TXOBJ] == (|$past(TX_FIFO_PENDING)))
        else $error("transmit object summary wrong");
endmodule
`default_nettype wire

// file: verif/can_irq_flags_test.sv
// Purpose: Self-checking bench for the CAN flag collection block over APB.
// Assumes: Slave answers with PREADY one cycle into the access phase.
// Notes:   Events are pulsed one cycle; summaries are driven as levels.
`default_nettype none
module can_irq_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    import can_irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic [3:0]  pstrb    = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  evt      = 4'h0;
    logic [2:0]  cur_mode = 3'h0;
    logic [2:0]  req_mode = 3'h0;
    logic [31:0] stamp    = 32'h0;
    logic [23:0] rxf      = 24'h0;
    logic [23:0] rxf_en   = 24'h0;
    logic [7:1]  rxov     = 7'h0;
    logic [7:0]  txat     = 8'h0;
    logic [7:0]  txf      = 8'h0;
    logic        tef      = 1'b0;
    logic        irq;
    int          mismatches  = 0;
    int          comparisons = 0;
    logic [15:0] exp;
    logic [15:0] sum_bits [4] = '{16'h0400, 16'h0800, 16'h0010, 16'h0001};

    // 50 MHz clock
    always #10 clk = ~clk;

    can_irq_flags u_dut (
        .CLK(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr),
        .IVM_EVT(evt[3]), .WAKE_EVT(evt[2]), .BERR_EVT(evt[1]), .SERR_EVT(evt[0]),
        .CURRENT_OP_MODE(cur_mode), .REQUESTED_OP_MODE(req_mode),
        .TIMESTAMP_BASE_COUNTER(stamp),
        .RX_FIFO_FLAGS(rxf), .RX_FIFO_FLAG_EN(rxf_en), .RX_FIFO_OVERFLOW(rxov),
        .TX_ATTEMPT_PENDING(txat), .TX_FIFO_PENDING(txf),
        .TX_EVENT_FIFO_PENDING(tef), .IRQ_REQ(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, the single exit of the run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // One APB transfer; ev is driven in the cycle whose edge commits a write,
    // so a set can race the software clear on purpose
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] st, input logic [3:0] ev,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= st;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            evt <= (n == 0) ? ev : 4'h0;
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk("pready timeout", 32'h1, 32'h0);
            final_report();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] st = 4'h3, input logic [3:0] ev = 4'h0);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, st, ev, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what,
                      input logic e_err = 1'b0);
        logic [31:0] r;
        logic        er;
        xfer(1'b0, a, 32'h0, 4'h0, 4'h0, r, er);
        chk(what, e, r);
        chk({what, " slverr"}, {31'h0, e_err}, {31'h0, er});
    endtask

    // Interrupt line is registered one cycle behind the register edge
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic pulse(input logic [3:0] ev);
        @(posedge clk);
        evt <= ev;
        @(posedge clk);
        evt <= 4'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        rd(ADDR_FLAGS, 32'h0, "flags reset");
        rd(ADDR_ENABLE, 32'h0, "enable reset");
        rd(ADDR_RXP_LOW, 32'h0, "rx pend low reset");
        rd(ADDR_RXP_HIGH, 32'h0, "rx pend high reset");
        rd(12'h010, 32'h0, "unmapped", 1'b1);
        // Software cannot set flags; unimplemented bits read zero
        wr(ADDR_FLAGS, 32'hffffffff);
        rd(ADDR_FLAGS, 32'h0, "flags after ones");
        wr(ADDR_ENABLE, 32'hffffffff);
        rd(ADDR_ENABLE, {16'h0, FLAG_MASK}, "enable mask");
        wr(ADDR_ENABLE, 32'h0);
        // Each event strobe, masked then enabled, then cleared by zero
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            exp = 16'h1000 << i;
            repeat (3) @(posedge clk);
            rd(ADDR_FLAGS, {16'h0, exp}, "event flag");
            irq_chk(1'b0);
            wr(ADDR_ENABLE, {16'h0, exp});
            irq_chk(1'b1);
            wr(ADDR_FLAGS, {16'hffff, ~exp});
            rd(ADDR_FLAGS, 32'h0, "flag cleared");
            irq_chk(1'b0);
        end
        wr(ADDR_ENABLE, 32'h0);
        // Set in the clearing cycle wins over the clear, invalid message too
        pulse(4'h9);
        wr(ADDR_FLAGS, 32'h0, 4'h3, 4'ha);
        rd(ADDR_FLAGS, 32'ha000, "set beats clear");
        wr(ADDR_FLAGS, 32'h0);
        // Mode flag only on a change that reaches the requested mode
        req_mode <= 3'h2;
        cur_mode <= 3'h1;
        repeat (3) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0, "mode no match");
        cur_mode <= 3'h2;
        repeat (3) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0008, "mode match");
        // Timer flag only on a wrap past the maximum
        stamp <= 32'hfffffffe;
        @(posedge clk);
        stamp <= 32'h0;
        @(posedge clk);
        stamp <= 32'hffffffff;
        @(posedge clk);
        stamp <= 32'h0;
        repeat (3) @(posedge clk);
        pulse(4'h1);
        repeat (2) @(posedge clk);
        rd(ADDR_FLAGS, 32'h100c, "mode timer serr");
        // Byte lanes: upper lane clears only bits 15:8, no lane clears none
        wr(ADDR_FLAGS, 32'h0, 4'h2);
        rd(ADDR_FLAGS, 32'h000c, "upper lane clear");
        wr(ADDR_FLAGS, 32'h0, 4'h0);
        rd(ADDR_FLAGS, 32'h000c, "no lane");
        wr(ADDR_FLAGS, 32'h0, 4'h1);
        rd(ADDR_FLAGS, 32'h0, "lower lane clear");
        // Read-only summaries follow their sources and ignore writes
        for (int k = 0; k < 4; k++) begin
            txat <= (k == 0) ? 8'h80 : 8'h00;
            rxov <= (k == 1) ? 7'h40 : 7'h00;
            tef  <= (k == 2);
            txf  <= (k == 3) ? 8'h80 : 8'h00;
            repeat (2) @(posedge clk);
            wr(ADDR_FLAGS, 32'h0);
            rd(ADDR_FLAGS, {16'h0, sum_bits[k]}, "summary");
            wr(ADDR_ENABLE, {16'h0, sum_bits[k]});
            irq_chk(1'b1);
        end
        {txat, rxov, tef, txf} <= '0;
        repeat (2) @(posedge clk);
        rd(ADDR_FLAGS, 32'h0, "summary released");
        irq_chk(1'b0);
        // Receive pending: only enabled flags count, FIFO 0 never shows
        for (int i = 0; i < 8; i++) begin
            rxf    <= 24'h1 << (3 * i + i % 3);
            rxf_en <= ~(24'h1 << (3 * i + i % 3));
            repeat (3) @(posedge clk);
            rd(ADDR_RXP_LOW, 32'h0, "rx pend disabled");
            rxf_en <= 24'h1 << (3 * i + i % 3);
            repeat (3) @(posedge clk);
            exp = (i > 0) ? (16'h1 << i) : 16'h0;
            rd(ADDR_RXP_LOW, {16'h0, exp}, "rx pend low");
            rd(ADDR_RXP_HIGH, 32'h0, "rx pend high");
            rd(ADDR_FLAGS, (i > 0) ? 32'h2 : 32'h0, "rx object");
        end
        rxf    <= 24'hffffff;
        rxf_en <= 24'hffffff;
        repeat (3) @(posedge clk);
        wr(ADDR_RXP_LOW, 32'h0);
        rd(ADDR_RXP_LOW, {16'h0, RXP_MASK}, "rx pend all");
        rxf <= 24'h0;
        repeat (3) @(posedge clk);
        rd(ADDR_RXP_LOW, 32'h0, "rx pend dropped");
        // Second reset in mid-run clears flags and enables
        pulse(4'hf);
        wr(ADDR_ENABLE, 32'hffff);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_FLAGS, 32'h0, "flags second reset");
        rd(ADDR_ENABLE, 32'h0, "enable second reset");
        irq_chk(1'b0);
        final_report();
    end
endmodule
`default_nettype wire
